// *** tb/radio_link_assertions.sv ***
// Pin-level checker for the serial link between module and host
`timescale 1ns/1ps
`default_nettype none
module radio_link_assertions #(
	parameter int DIV = 86
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic h2d,
	input wire logic d2h,
	input wire logic dev_rts_n,
	input wire logic host_rts_n,
	input wire logic mode_sel,
	input wire logic boot_sel,
	input wire logic wake
);
	int run [2]; // Low samples in a row, 0 h2d, 1 d2h
	int pos [2]; // Edges since a start bit was first seen
	logic act [2]; // Character in flight
	logic [1:0] ln;
	assign ln = {d2h, h2d};
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	// Frame tracker; a start is only looked for between characters
	always_ff @(posedge clk) begin
		for (int i = 0; i < 2; i++) begin
			if (rst) begin
				run[i] <= 0;
				pos[i] <= 0;
				act[i] <= 1'b0;
			end else begin
				run[i] <= ln[i] ? 0 : run[i] + 1;
				if (act[i]) begin // Ten bit times, then idle again
					pos[i] <= (pos[i] == 10 * DIV - 1) ? 0 : pos[i] + 1;
					act[i] <= pos[i] != 10 * DIV - 1;
				end else if (!ln[i]) begin // Start bit seen
					act[i] <= 1'b1;
					pos[i] <= 1;
				end
			end
		end
	end
	// Host start bit stays low for at least eight cycles, not a glitch
	sequence s_low8;
		!h2d [*8];
	endsequence
	property p_h2d_start;
		!act[0] && $fell(h2d) |-> s_low8;
	endproperty
	a_h2d_start: assert property (p_h2d_start)
		else $error("host start bit too short");
	property p_h2d_rel_idle;
		$fell(rst) |-> h2d ##1 h2d;
	endproperty
	a_h2d_rel_idle: assert property (p_h2d_rel_idle)
		else $error("host line not idle after reset");
	property p_d2h_rel_idle;
		$fell(rst) |-> d2h ##1 d2h;
	endproperty
	a_d2h_rel_idle: assert property (p_d2h_rel_idle)
		else $error("module line not idle after reset");
	property p_h2d_bits;
		$rose(h2d) |-> run[0] % DIV == 0;
	endproperty
	a_h2d_bits: assert property (p_h2d_bits)
		else $error("host bit width not the rate divisor");
	property p_d2h_bits;
		$rose(d2h) |-> run[1] % DIV == 0;
	endproperty
	a_d2h_bits: assert property (p_d2h_bits)
		else $error("module bit width not the rate divisor");
	property p_h2d_stop;
		act[0] && pos[0] == 9 * DIV + DIV / 2 |-> h2d;
	endproperty
	a_h2d_stop: assert property (p_h2d_stop)
		else $error("host stop bit low");
	property p_d2h_stop;
		act[1] && pos[1] == 9 * DIV + DIV / 2 |-> d2h;
	endproperty
	a_d2h_stop: assert property (p_d2h_stop)
		else $error("module stop bit low");
	property p_straps_held;
		$fell(rst) |-> $stable(mode_sel) && $stable(boot_sel);
	endproperty
	a_straps_held: assert property (p_straps_held)
		else $error("strap changed at reset release");
	// Default rate without boot request: no flow control either way
	property p_dev_rts_free;
		boot_sel |-> !dev_rts_n;
	endproperty
	a_dev_rts_free: assert property (p_dev_rts_free)
		else $error("module throttles at default rate");
	property p_host_rts_free;
		boot_sel |-> !host_rts_n;
	endproperty
	a_host_rts_free: assert property (p_host_rts_free)
		else $error("host throttles at default rate");
	c_wake: cover property ($rose(wake));
endmodule : radio_link_assertions
`default_nettype wire

// *** tb/radio_module_host_uart_framer_test.sv ***
// Self-checking bench joining both ends of the radio serial link
`timescale 1ns/1ps
`default_nettype none
module radio_module_host_uart_framer_test import radio_uart_pkg::*;;
	typedef logic [7:0] bq_t [$];
	localparam int BIT_DIV = CLK_HZ / 115200; // Default rate only
	int seed = 32'h2310c0fd;
	int num_errors = 0;
	int n_compared = 0;
	int cycles = 0;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic trig_etx = 1'b0;
	logic [3:0] rate_sel = 4'h7; // Module rate code from the bench
	logic rate_load = 1'b0;
	logic tx_ready = 1'b1; // Radio side stalls at random
	logic rx_start = 1'b0;
	logic [15:0] rx_len = 16'h0000;
	logic [31:0] rx_src = 32'h00000000;
	logic [7:0] rx_rssi = 8'h00;
	logic rx_valid = 1'b0;
	logic [7:0] rx_data = 8'h00;
	logic want_cmd = 1'b1;
	logic want_boot = 1'b0;
	logic wake_req = 1'b0;
	logic frm_start = 1'b0;
	logic [7:0] frm_code = 8'h00;
	logic [15:0] frm_len = 16'h0000;
	logic snd_valid = 1'b0;
	logic [7:0] snd_data = 8'h00;
	logic tx_valid, tx_go, tx_drop, rx_ready, cmd_mode, sleeping;
	logic boot_mode, flow_on, fw_valid, snd_ready, rcv_valid, busy;
	logic [7:0] tx_data, fw_data, rcv_data;
	tx_kind_t tx_kind;
	bq_t radio_q, host_q, fw_q;
	logic [1:0] go_q [$]; // Send kinds seen with each go
	int n_drop = 0;
	radio_uart_if u_radio_uart_if ();
	radio_dev_end #(.IDLE_WAIT(2000)) u_radio_dev_end (.clk(clk),
		.rst(rst), .link(u_radio_uart_if), .rate_sel(rate_sel),
		.rate_load(rate_load), .trig_etx(trig_etx), .tx_valid(tx_valid),
		.tx_data(tx_data), .tx_ready(tx_ready), .tx_go(tx_go),
		.tx_drop(tx_drop), .tx_kind(tx_kind), .rx_start(rx_start),
		.rx_len(rx_len), .rx_src(rx_src), .rx_rssi(rx_rssi),
		.rx_valid(rx_valid), .rx_data(rx_data), .rx_ready(rx_ready),
		.cmd_mode(cmd_mode), .sleeping(sleeping), .boot_mode(boot_mode),
		.flow_on(flow_on), .fw_valid(fw_valid), .fw_data(fw_data));
	radio_host_end u_radio_host_end (.clk(clk), .rst(rst),
		.link(u_radio_uart_if), .rate_sel(4'h7), .rate_load(1'b0),
		.want_cmd(want_cmd), .want_boot(want_boot), .wake_req(wake_req),
		.frm_start(frm_start), .frm_code(frm_code), .frm_len(frm_len),
		.snd_valid(snd_valid), .snd_data(snd_data), .snd_ready(snd_ready),
		.rcv_ready(1'b1), .rcv_valid(rcv_valid), .rcv_data(rcv_data),
		.busy(busy));
	radio_link_assertions #(.DIV(BIT_DIV)) u_radio_link_assertions (
		.clk(clk), .rst(rst), .h2d(u_radio_uart_if.h2d),
		.d2h(u_radio_uart_if.d2h), .dev_rts_n(u_radio_uart_if.dev_rts_n),
		.host_rts_n(u_radio_uart_if.host_rts_n),
		.mode_sel(u_radio_uart_if.mode_sel),
		.boot_sel(u_radio_uart_if.boot_sel), .wake(u_radio_uart_if.wake));
	// 100 ns clock
	initial begin
		forever #50 clk = ~clk;
	end
	// Collect outputs, stall the radio, cut a hang short
	always @(posedge clk) begin
		tx_ready <= 1'($random(seed));
		if (tx_valid && tx_ready) radio_q.push_back(tx_data);
		if (rcv_valid) host_q.push_back(rcv_data);
		if (fw_valid) fw_q.push_back(fw_data);
		if (tx_go) go_q.push_back(tx_kind);
		if (tx_drop) n_drop++;
		cycles++;
		if (cycles == 80000) begin // Far beyond the planned run
			num_errors++;
			stop_test();
		end
	end
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp) begin
			num_errors++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	task automatic stop_test();
		$display("compared %0d mismatches %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : stop_test
	// Straps held through the whole reset; radio, host and go queues emptied
	task automatic do_reset(input logic cmd, input logic boot);
		rst <= 1'b1;
		want_cmd <= cmd;
		want_boot <= boot;
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		repeat (2) @(posedge clk);
		radio_q.delete();
		host_q.delete();
		go_q.delete();
	endtask : do_reset
	// Host bytes; valid stays up between bytes, so no double drive
	task automatic put_q(input bq_t pl);
		@(posedge clk);
		foreach (pl[i]) begin
			snd_valid <= 1'b1;
			snd_data <= pl[i];
			@(posedge clk iff snd_ready);
		end
		snd_valid <= 1'b0;
	endtask : put_q
	task automatic send(input logic [7:0] code, input bq_t pl);
		@(posedge clk iff !busy);
		frm_start <= 1'b1;
		frm_code <= code;
		frm_len <= 16'(pl.size());
		@(posedge clk);
		frm_start <= 1'b0;
		put_q(pl);
	endtask : send
	// Radio packet into the module, with or without indication header
	task automatic radio_in(input bq_t pl, input logic hdr);
		@(posedge clk);
		if (hdr) begin
			rx_start <= 1'b1;
			@(posedge clk);
			rx_start <= 1'b0;
		end
		foreach (pl[i]) begin
			rx_valid <= 1'b1;
			rx_data <= pl[i];
			@(posedge clk iff rx_ready);
		end
		rx_valid <= 1'b0;
	endtask : radio_in
	function automatic bq_t rnd_bytes(input int n);
		bq_t q;
		for (int i = 0; i < n; i++) q.push_back(8'($random(seed)));
		return q;
	endfunction : rnd_bytes
	// Expected indication: header, address LSB first, strength, data, sum
	function automatic bq_t ind_frame(input logic [31:0] src,
		input logic [7:0] rs, input bq_t d);
		bq_t q;
		logic [15:0] n;
		logic [7:0] cs;
		n = 16'(d.size()) + 16'h0005;
		q = '{8'h02, 8'h84, n[7:0], n[15:8], src[7:0], src[15:8],
			src[23:16], src[31:24], rs};
		foreach (d[i]) q.push_back(d[i]);
		cs = 8'h00;
		foreach (q[i]) cs ^= q[i];
		q.push_back(cs);
		return q;
	endfunction : ind_frame
	// Main sequence
	initial begin
		bq_t pl, ex, none;
		logic [7:0] b;
		do_reset(1'b1, 1'b0);
		chk(cmd_mode, 1);
		chk(boot_mode, 0);
		chk(flow_on, 0);
		// Codes past the rate table are ignored: rate and flow stay put
		rate_sel <= 4'hc | 4'($random(seed));
		rate_load <= 1'b1;
		@(posedge clk);
		rate_load <= 1'b0;
		@(posedge clk);
		chk(flow_on, 0);
		// Each send kind, payload length one to three
		for (int k = 0; k < 3; k++) begin
			pl = rnd_bytes(k + 1);
			send(CMD_BCAST + 8'(k), pl);
			while (go_q.size() == 0) @(posedge clk);
			chk(go_q.pop_front(), 16'(k));
			chk(16'(radio_q.size()), 16'(k + 1));
			foreach (pl[i]) chk(radio_q.pop_front(), pl[i]);
		end
		chk(16'(n_drop), 0);
		// Raw unicast frame with a corrupt checksum: payload then drop
		b = 8'($random(seed));
		pl = '{START_BYTE, CMD_UCAST, 8'h01, 8'h00, b,
			START_BYTE ^ CMD_UCAST ^ 8'h01 ^ b ^ 8'h80};
		put_q(pl);
		while (n_drop == 0) @(posedge clk);
		repeat (4) @(posedge clk);
		chk(16'(n_drop), 1);
		chk(16'(go_q.size()), 0);
		radio_q.delete();
		// Radio packet reported to the host
		pl = rnd_bytes(3);
		b = 8'($random(seed));
		rx_src <= $random(seed);
		rx_rssi <= b;
		rx_len <= 16'h0003;
		@(posedge clk);
		ex = ind_frame(rx_src, b, pl);
		radio_in(pl, 1'b1);
		while (host_q.size() < ex.size()) @(posedge clk);
		foreach (ex[i]) chk(host_q[i], ex[i]);
		// Sleep by command, wake by pin
		send(CMD_SLEEP, none);
		@(posedge clk iff !busy);
		for (int i = 0; i < 2 * BIT_DIV && !sleeping; i++) @(posedge clk);
		chk(sleeping, 1);
		wake_req <= 1'b1;
		for (int i = 0; i < 8 && sleeping; i++) @(posedge clk);
		chk(sleeping, 0);
		wake_req <= 1'b0;
		// Transparent, idle timeout sends once after the last byte
		do_reset(1'b0, 1'b0);
		chk(cmd_mode, 0);
		pl = rnd_bytes(3);
		put_q(pl);
		while (go_q.size() == 0) @(posedge clk);
		chk(16'(radio_q.size()), 3);
		foreach (pl[i]) chk(radio_q.pop_front(), pl[i]);
		// End-of-text trigger ignores idle time
		go_q.delete();
		trig_etx <= 1'b1;
		pl = '{8'($random(seed)) | 8'h80};
		put_q(pl);
		repeat (3500) @(posedge clk);
		chk(16'(go_q.size()), 0);
		pl.push_back(ETX_BYTE);
		put_q('{ETX_BYTE});
		while (go_q.size() == 0) @(posedge clk);
		foreach (pl[i]) chk(radio_q.pop_front(), pl[i]);
		// Radio byte goes out raw
		pl = rnd_bytes(1);
		radio_in(pl, 1'b0);
		repeat (12 * BIT_DIV) @(posedge clk);
		chk(16'(host_q.size()), 1);
		chk(host_q[0], pl[0]);
		// Boot strap: flow control on, bytes go to firmware
		do_reset(1'b1, 1'b1);
		chk(boot_mode, 1);
		chk(flow_on, 1);
		pl = rnd_bytes(1);
		put_q(pl);
		while (fw_q.size() == 0) @(posedge clk);
		chk(fw_q[0], pl[0]);
		chk(16'(radio_q.size()), 0);
		stop_test();
	end
endmodule : radio_module_host_uart_framer_test
`default_nettype wire

// *** verilog/radio_dev_end.sv ***
// Radio module end of the host serial link: framing, straps, sleep
`timescale 1ns/1ps
`default_nettype none
module radio_dev_end import radio_uart_pkg::*; #(
	parameter int CLK_FREQ = CLK_HZ,
	parameter int IDLE_WAIT = IDLE_CYCLES,
	parameter bit LEGACY = 1'b0
) (
	input wire logic clk,
	input wire logic rst,
	radio_uart_if.dev link,
	input wire logic [3:0] rate_sel,
	input wire logic rate_load,
	input wire logic trig_etx,
	output logic tx_valid,
	output logic [7:0] tx_data,
	input wire logic tx_ready,
	output logic tx_go,
	output logic tx_drop,
	output tx_kind_t tx_kind,
	input wire logic rx_start,
	input wire logic [15:0] rx_len,
	input wire logic [31:0] rx_src,
	input wire logic [7:0] rx_rssi,
	input wire logic rx_valid,
	input wire logic [7:0] rx_data,
	output logic rx_ready,
	output logic cmd_mode,
	output logic sleeping,
	output logic boot_mode,
	output logic flow_on,
	output logic fw_valid,
	output logic [7:0] fw_data
);
	typedef enum {O_IDLE, O_START, O_CODE, O_LEN0, O_LEN1, O_ADDR, O_RSSI,
		O_DATA, O_CS} out_state_t;
	typedef enum {I_START, I_CODE, I_LEN0, I_LEN1, I_PAY, I_CS} in_state_t;
	logic [3:0] rate; // Active rate index
	logic [15:0] div; // Cycles per bit
	logic [15:0] rx_cnt, tx_cnt; // Bit timers
	logic [3:0] rx_bit, tx_left; // Bit positions
	logic [7:0] rx_sh; // Receive shifter
	logic [9:0] tx_sh; // Transmit shifter, bit 0 on the line
	logic rx_busy, rx_got; // Receive active, byte done pulse
	logic [7:0] rx_byte; // Last byte from host
	logic out_valid, out_take; // Byte offered to and taken by transmitter
	logic [7:0] out_byte;
	out_state_t ost; // Indication framer state
	logic [15:0] olen, ocnt; // Length field and data count
	logic [31:0] osrc; // Latched source address
	logic [7:0] orssi, ocs; // Latched strength, running checksum
	in_state_t ist; // Command parser state
	logic [7:0] icode, ics; // Command code, running checksum
	logic [15:0] ilen, icnt; // Payload length and count
	logic fin_pend, fin_good; // Frame end waiting for last byte to drain
	logic [31:0] idle_cnt; // Transparent idle timer
	logic pending; // Transparent bytes not yet sent

	// Straps caught while reset is held; last value before release wins
	always_ff @(posedge clk) begin
		if (rst) begin
			cmd_mode <= !link.mode_sel;
			boot_mode <= (link.boot_sel == LEGACY);
		end
	end

	// Rate register, unknown codes ignored
	always_ff @(posedge clk) begin
		if (rst) begin
			rate <= RATE_DEFAULT;
		end else if (rate_load && rate_sel < 4'(NUM_RATES)) begin
			rate <= rate_sel;
		end
	end

	// Table is ordered, so any index past the default is a faster rate
	assign div = rate_div(CLK_FREQ, rate);
	assign flow_on = (rate > RATE_DEFAULT) || boot_mode;
	// Without flow control the host may overrun a stalled radio
	assign link.dev_rts_n = flow_on && (tx_valid || fin_pend);

	// Receiver: middle-of-bit sampling, no parity, stop must be high
	always_ff @(posedge clk) begin
		rx_got <= 1'b0;
		if (rst) begin
			rx_busy <= 1'b0;
			rx_cnt <= 16'h0000;
			rx_bit <= 4'h0;
			rx_sh <= 8'h00;
			rx_byte <= 8'h00;
		end else if (!rx_busy) begin
			if (!link.h2d) begin
				rx_busy <= 1'b1;
				rx_cnt <= div >> 1;
				rx_bit <= 4'h0;
			end
		end else if (rx_cnt != 16'h0000) begin
			rx_cnt <= rx_cnt - 16'h0001;
		end else begin
			rx_cnt <= div - 16'h0001;
			rx_bit <= rx_bit + 4'h1;
			if (rx_bit == 4'h0 && link.h2d) begin
				rx_busy <= 1'b0; // Glitch, not a start bit
			end else if (rx_bit == CHAR_BITS - 4'h1) begin
				rx_busy <= 1'b0;
				rx_got <= link.h2d; // Framing error drops it
				rx_byte <= rx_sh;
			end else if (rx_bit != 4'h0) begin
				rx_sh <= {link.h2d, rx_sh[7:1]};
			end
		end
	end

	// Transmitter waits on the host handshake when flow is on
	assign out_take = out_valid && tx_left == 4'h0 &&
		(!flow_on || !link.host_rts_n);
	assign link.d2h = tx_sh[0];
	always_ff @(posedge clk) begin
		if (rst) begin
			tx_sh <= 10'h3ff;
			tx_left <= 4'h0;
			tx_cnt <= 16'h0000;
		end else if (tx_left == 4'h0) begin
			if (out_take) begin
				tx_sh <= {1'b1, out_byte, 1'b0};
				tx_left <= CHAR_BITS;
				tx_cnt <= div - 16'h0001;
			end
		end else if (tx_cnt != 16'h0000) begin
			tx_cnt <= tx_cnt - 16'h0001;
		end else begin
			tx_sh <= {1'b1, tx_sh[9:1]};
			tx_left <= tx_left - 4'h1;
			tx_cnt <= div - 16'h0001;
		end
	end

	// Byte offered by the indication framer or the raw path
	always_comb begin
		out_valid = 1'b1;
		out_byte = 8'h00;
		rx_ready = 1'b0;
		unique case (ost)
			O_IDLE: begin
				out_valid = 1'b0;
				if (!cmd_mode && !boot_mode) begin
					out_valid = rx_valid;
					out_byte = rx_data;
					rx_ready = out_take;
				end
			end
			O_START: out_byte = START_BYTE;
			O_CODE: out_byte = LEGACY ? IND_CODE_LEGACY : IND_CODE;
			O_LEN0: out_byte = olen[7:0];
			O_LEN1: out_byte = olen[15:8];
			O_ADDR: out_byte = osrc[7:0];
			O_RSSI: out_byte = orssi;
			O_DATA: begin
				out_valid = rx_valid;
				out_byte = rx_data;
				rx_ready = out_take;
			end
			O_CS: out_byte = ocs;
		endcase
	end

	// Indication framer sequencing
	always_ff @(posedge clk) begin
		if (rst) begin
			ost <= O_IDLE;
			olen <= 16'h0000;
			ocnt <= 16'h0000;
			osrc <= 32'h0;
			orssi <= 8'h00;
			ocs <= 8'h00;
		end else if (ost == O_IDLE) begin
			if (cmd_mode && !boot_mode && !sleeping && rx_start) begin
				ost <= O_START;
				olen <= rx_len + (LEGACY ? IND_EXTRA_LEGACY : IND_EXTRA);
				ocnt <= rx_len;
				osrc <= rx_src;
				orssi <= rx_rssi;
				ocs <= 8'h00;
			end
		end else if (out_take) begin
			ocs <= ocs ^ out_byte;
			unique case (ost)
				O_START: ost <= O_CODE;
				O_CODE: ost <= O_LEN0;
				O_LEN0: begin
					if (LEGACY) begin
						ost <= (ocnt == 16'h0000) ? O_RSSI : O_DATA;
					end else begin
						ost <= O_LEN1;
					end
				end
				O_LEN1: begin
					// Length is out; its low bits now count address bytes
					olen <= 16'h0000;
					ost <= O_ADDR;
				end
				O_ADDR: begin // Low address byte first
					osrc <= {8'h00, osrc[31:8]};
					olen[2:0] <= olen[2:0] + 3'h1;
					if (olen[2:0] + 3'h1 == ADDR_BYTES) begin
						ost <= O_RSSI;
					end
				end
				O_RSSI: begin
					if (LEGACY || ocnt == 16'h0000) begin
						ost <= O_CS;
					end else begin
						ost <= O_DATA;
					end
				end
				O_DATA: begin
					ocnt <= ocnt - 16'h0001;
					if (ocnt == 16'h0001) begin
						ost <= LEGACY ? O_RSSI : O_CS;
					end
				end
				O_CS: ost <= O_IDLE;
				default: ost <= O_IDLE;
			endcase
		end
	end

	// Command parser, transparent path and firmware path
	always_ff @(posedge clk) begin
		tx_go <= 1'b0;
		tx_drop <= 1'b0;
		fw_valid <= 1'b0;
		if (rst) begin
			ist <= I_START;
			icode <= 8'h00;
			ics <= 8'h00;
			ilen <= 16'h0000;
			icnt <= 16'h0000;
			tx_valid <= 1'b0;
			tx_data <= 8'h00;
			tx_kind <= KIND_BCAST;
			fin_pend <= 1'b0;
			fin_good <= 1'b0;
			sleeping <= 1'b0;
			pending <= 1'b0;
			idle_cnt <= 32'h0;
			fw_data <= 8'h00;
		end else begin
			if (tx_valid && tx_ready) begin
				tx_valid <= 1'b0;
			end
			// Finish a frame only once its last byte has drained
			if (fin_pend && !tx_valid) begin
				fin_pend <= 1'b0;
				tx_go <= fin_good;
				tx_drop <= !fin_good;
			end
			if (sleeping && link.wake) begin
				sleeping <= 1'b0;
			end
			if (!cmd_mode && !boot_mode && pending && !trig_etx) begin
				idle_cnt <= idle_cnt + 32'h1;
				if (idle_cnt + 32'h1 >= 32'(IDLE_WAIT)) begin
					pending <= 1'b0; // Timeout trigger
					fin_pend <= 1'b1;
					fin_good <= 1'b1;
				end
			end
			if (rx_got && boot_mode) begin
				fw_valid <= 1'b1; // Never leaves boot mode
				fw_data <= rx_byte;
			end else if (rx_got && !cmd_mode) begin
				tx_valid <= 1'b1;
				tx_data <= rx_byte;
				idle_cnt <= 32'h0;
				pending <= !(trig_etx && rx_byte == ETX_BYTE);
				if (trig_etx && rx_byte == ETX_BYTE) begin
					fin_pend <= 1'b1; // End-of-text trigger
					fin_good <= 1'b1;
				end
			end else if (rx_got && !sleeping) begin
				ics <= ics ^ rx_byte;
				unique case (ist)
					I_START: begin
						ics <= rx_byte;
						if (rx_byte == START_BYTE) begin
							ist <= I_CODE;
						end
					end
					I_CODE: begin
						icode <= rx_byte;
						ist <= I_LEN0;
					end
					I_LEN0: begin
						ilen <= {8'h00, rx_byte};
						icnt <= 16'h0000;
						if (LEGACY) begin
							ist <= (rx_byte == 8'h00) ? I_CS : I_PAY;
						end else begin
							ist <= I_LEN1;
						end
					end
					I_LEN1: begin
						ilen[15:8] <= rx_byte;
						ist <= ({rx_byte, ilen[7:0]} == 16'h0000) ? I_CS : I_PAY;
					end
					I_PAY: begin
						if (icode >= CMD_BCAST && icode <= CMD_UCAST) begin
							tx_valid <= 1'b1;
							tx_data <= rx_byte;
						end
						icnt <= icnt + 16'h0001;
						if (icnt + 16'h0001 == ilen) begin
							ist <= I_CS;
						end
					end
					I_CS: begin
						ist <= I_START;
						// One star network; the code only picks the kind
						if (icode >= CMD_BCAST && icode <= CMD_UCAST) begin
							tx_kind <= tx_kind_t'(icode[1:0]);
							fin_pend <= 1'b1;
							fin_good <= (ics == rx_byte);
						end else if (icode == CMD_SLEEP && ics == rx_byte) begin
							sleeping <= 1'b1;
						end
					end
				endcase
			end
		end
	end
endmodule : radio_dev_end
`default_nettype wire

// *** verilog/radio_host_end.sv ***
// Host controller end of the radio module serial link
`timescale 1ns/1ps
`default_nettype none
module radio_host_end import radio_uart_pkg::*; #(
	parameter int CLK_FREQ = CLK_HZ,
	parameter bit LEGACY = 1'b0
) (
	input wire logic clk,
	input wire logic rst,
	radio_uart_if.host link,
	input wire logic [3:0] rate_sel,
	input wire logic rate_load,
	input wire logic want_cmd,
	input wire logic want_boot,
	input wire logic wake_req,
	input wire logic frm_start,
	input wire logic [7:0] frm_code,
	input wire logic [15:0] frm_len,
	input wire logic snd_valid,
	input wire logic [7:0] snd_data,
	output logic snd_ready,
	input wire logic rcv_ready,
	output logic rcv_valid,
	output logic [7:0] rcv_data,
	output logic busy
);
	typedef enum {S_IDLE, S_START, S_CODE, S_LEN0, S_LEN1, S_PAY,
		S_CS} snd_state_t;
	logic [3:0] rate; // Rate index, must match the module
	logic [15:0] div, rx_cnt, tx_cnt; // Bit timing
	logic [3:0] rx_bit, tx_left;
	logic [7:0] rx_sh;
	logic [9:0] tx_sh;
	logic rx_busy, flow_on, out_valid, out_take;
	logic [7:0] out_byte, cs; // Offered byte, running checksum
	snd_state_t st; // Frame builder state
	logic [7:0] code;
	logic [15:0] len, cnt;

	// Straps and wake are plain levels from the user
	assign link.mode_sel = !want_cmd;
	assign link.boot_sel = want_boot ? LEGACY : !LEGACY;
	assign link.wake = wake_req;

	// Rate register mirrors the module setting
	always_ff @(posedge clk) begin
		if (rst) begin
			rate <= RATE_DEFAULT;
		end else if (rate_load && rate_sel < 4'(NUM_RATES)) begin
			rate <= rate_sel;
		end
	end
	assign div = rate_div(CLK_FREQ, rate);
	assign flow_on = (rate > RATE_DEFAULT) || want_boot;
	// Refuse bytes while the user is not ready, when flow is on
	assign link.host_rts_n = flow_on && !rcv_ready;

	// Receiver, same sampling scheme as the module
	always_ff @(posedge clk) begin
		rcv_valid <= 1'b0;
		if (rst) begin
			rx_busy <= 1'b0;
			rx_cnt <= 16'h0000;
			rx_bit <= 4'h0;
			rx_sh <= 8'h00;
			rcv_data <= 8'h00;
		end else if (!rx_busy) begin
			if (!link.d2h) begin
				rx_busy <= 1'b1;
				rx_cnt <= div >> 1;
				rx_bit <= 4'h0;
			end
		end else if (rx_cnt != 16'h0000) begin
			rx_cnt <= rx_cnt - 16'h0001;
		end else begin
			rx_cnt <= div - 16'h0001;
			rx_bit <= rx_bit + 4'h1;
			if (rx_bit == 4'h0 && link.d2h) begin
				rx_busy <= 1'b0;
			end else if (rx_bit == CHAR_BITS - 4'h1) begin
				rx_busy <= 1'b0;
				rcv_valid <= link.d2h;
				rcv_data <= rx_sh;
			end else if (rx_bit != 4'h0) begin
				rx_sh <= {link.d2h, rx_sh[7:1]};
			end
		end
	end

	// Transmitter honours the module handshake when flow is on
	assign out_take = out_valid && tx_left == 4'h0 &&
		(!flow_on || !link.dev_rts_n);
	assign link.h2d = tx_sh[0];
	always_ff @(posedge clk) begin
		if (rst) begin
			tx_sh <= 10'h3ff;
			tx_left <= 4'h0;
			tx_cnt <= 16'h0000;
		end else if (tx_left == 4'h0) begin
			if (out_take) begin
				tx_sh <= {1'b1, out_byte, 1'b0};
				tx_left <= CHAR_BITS;
				tx_cnt <= div - 16'h0001;
			end
		end else if (tx_cnt != 16'h0000) begin
			tx_cnt <= tx_cnt - 16'h0001;
		end else begin
			tx_sh <= {1'b1, tx_sh[9:1]};
			tx_left <= tx_left - 4'h1;
			tx_cnt <= div - 16'h0001;
		end
	end

	// Offered byte: raw stream when idle, else frame field
	always_comb begin
		out_valid = 1'b1;
		out_byte = 8'h00;
		snd_ready = 1'b0;
		unique case (st)
			S_IDLE: begin
				out_valid = snd_valid;
				out_byte = snd_data;
				snd_ready = out_take;
			end
			S_START: out_byte = START_BYTE;
			S_CODE: out_byte = code;
			S_LEN0: out_byte = len[7:0];
			S_LEN1: out_byte = len[15:8];
			S_PAY: begin
				out_valid = snd_valid;
				out_byte = snd_data;
				snd_ready = out_take;
			end
			S_CS: out_byte = cs;
		endcase
	end
	assign busy = (st != S_IDLE) || (tx_left != 4'h0);

	// Frame builder; sleep is just a frame with the sleep code
	always_ff @(posedge clk) begin
		if (rst) begin
			st <= S_IDLE;
			code <= 8'h00;
			len <= 16'h0000;
			cnt <= 16'h0000;
			cs <= 8'h00;
		end else if (st == S_IDLE) begin
			if (frm_start && tx_left == 4'h0) begin
				st <= S_START;
				code <= frm_code;
				len <= LEGACY ? {8'h00, frm_len[7:0]} : frm_len;
				cs <= 8'h00;
			end
		end else if (out_take) begin
			cs <= cs ^ out_byte;
			unique case (st)
				S_START: st <= S_CODE;
				S_CODE: st <= S_LEN0;
				S_LEN0: begin
					cnt <= len;
					if (LEGACY) begin
						st <= (len == 16'h0000) ? S_CS : S_PAY;
					end else begin
						st <= S_LEN1;
					end
				end
				S_LEN1: st <= (len == 16'h0000) ? S_CS : S_PAY;
				S_PAY: begin
					cnt <= cnt - 16'h0001;
					if (cnt == 16'h0001) begin
						st <= S_CS;
					end
				end
				S_CS: st <= S_IDLE;
				default: st <= S_IDLE;
			endcase
		end
	end
endmodule : radio_host_end
`default_nettype wire

// *** verilog/radio_uart_if.sv ***
// Pin bundle between the radio module and its host controller
`timescale 1ns/1ps
`default_nettype none
interface radio_uart_if;
	logic h2d; // Serial data host to module, idle high
	logic d2h; // Serial data module to host, idle high
	logic dev_rts_n; // Module ready to take bytes, low = ready
	logic host_rts_n; // Host ready to take bytes, low = ready
	logic mode_sel; // Strap: low = command, high = transparent
	logic boot_sel; // Strap: boot mode request level
	logic wake; // High wakes the module from sleep
	modport dev(input h2d, host_rts_n, mode_sel, boot_sel, wake,
		output d2h, dev_rts_n);
	modport host(output h2d, host_rts_n, mode_sel, boot_sel, wake,
		input d2h, dev_rts_n);
endinterface : radio_uart_if
`default_nettype wire

// *** verilog/radio_uart_pkg.sv ***
// Shared constants and types for the radio module serial link
package radio_uart_pkg;
	// Core clock rate
	localparam int CLK_HZ = 10_000_000;
	// Discrete serial rates, slowest first; index is the rate select code
	localparam int NUM_RATES = 12;
	localparam int RATE_TABLE [NUM_RATES] = '{1200, 2400, 4800, 9600,
		19200, 38400, 57600, 115200, 230400, 460800, 921600, 1000000};
	// Index of the 115200 rate, the reset default
	localparam logic [3:0] RATE_DEFAULT = 4'h7;
	// Frame bytes
	localparam logic [7:0] START_BYTE = 8'h02;
	localparam logic [7:0] ETX_BYTE = 8'h03;
	localparam logic [7:0] IND_CODE = 8'h84;
	localparam logic [7:0] IND_CODE_LEGACY = 8'h81;
	// Radio send and sleep command codes
	localparam logic [7:0] CMD_BCAST = 8'h10;
	localparam logic [7:0] CMD_MCAST = 8'h11;
	localparam logic [7:0] CMD_UCAST = 8'h12;
	localparam logic [7:0] CMD_SLEEP = 8'h13;
	// Extra payload bytes in an indication: address plus strength, strength only in legacy
	localparam logic [15:0] IND_EXTRA = 16'h0005;
	localparam logic [15:0] IND_EXTRA_LEGACY = 16'h0001;
	localparam logic [2:0] ADDR_BYTES = 3'h4;
	// Serial bits per character: start, eight data, stop
	localparam logic [3:0] CHAR_BITS = 4'ha;
	// Idle time before a transparent radio send
	localparam int IDLE_TIMEOUT_US = 1000;
	localparam int IDLE_CYCLES = IDLE_TIMEOUT_US * (CLK_HZ / 1_000_000);
	// Radio send kinds
	typedef enum logic [1:0] {KIND_BCAST, KIND_MCAST, KIND_UCAST} tx_kind_t;
	// Clock cycles per serial bit for a rate index
	function automatic logic [15:0] rate_div(input int clk_hz,
		input logic [3:0] idx);
		int d;
		d = clk_hz / RATE_TABLE[idx];
		return d[15:0];
	endfunction : rate_div
endpackage : radio_uart_pkg
